// ==== cfe_flag_unit.sv ====
// condition flag evaluator: flags, condition gating and pc base
// Behaviour
// - direct branches use pc plus four unaligned
// - other labels: pc plus four, bit1 cleared
// - flags not updated keep previous value
// - failed condition: no write, flags, exception
// - negative result sets msb flag, else clear
// - zero result sets null flag, else clear
// - carry from add, nonnegative subtract, shifter
// - signed overflow of add, subtract, compare
// - flags update only with set suffix, except compares, which update without it
// - non-branch conditions only inside if-then block
// - single flag conditions test z n v
// - unsigned conditions test carry and zero
// - signed conditions compare sign and overflow
// - missing condition means always true
// - narrow and wide encodings behave alike except the sequential pc step (two or four)
`timescale 1ns/1ps
`include "cfe_params.svh"
module cfe_flag_unit
  import cfe_pkg::*;
#(
  parameter int ADDR_W = 2
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // decoded instruction
  input  wire logic              dec_valid,
  input  wire logic [31:0]       dec_pc,
  input  wire logic              dec_wide,
  input  wire logic [3:0]        dec_cond,
  input  wire logic              dec_in_it,
  input  wire logic              dec_is_branch,
  input  wire logic              dec_direct_br,
  input  wire logic [31:0]       dec_offset,
  input  wire logic [2:0]        dec_op,
  input  wire logic              dec_set_flags,
  input  wire logic [3:0]        dec_upd_mask,
  input  wire logic [31:0]       dec_opnd_a,
  input  wire logic [31:0]       dec_opnd_b,
  input  wire logic              dec_shc,
  input  wire logic              dec_shc_vld,
  input  wire logic              dec_wr_rd,
  input  wire logic              dec_exc,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // execute results
  output logic                   ex_valid,
  output logic                   ex_exec,
  output logic      [31:0]       ex_result,
  output logic                   ex_wr_en,
  output logic                   ex_exc,
  output logic                   ex_undef,
  output logic      [31:0]       ex_label_base,
  output logic      [31:0]       ex_target,
  output logic      [31:0]       ex_next_pc,
  output logic      [3:0]        app_status_word
);
  logic [3:0]  flags_reg, flags_next;
  logic        ctrl_strict_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic        ex_valid_reg, ex_exec_reg, ex_wr_en_reg;
  logic        ex_exc_reg, ex_undef_reg;
  logic [31:0] ex_result_reg, ex_base_reg, ex_target_reg, ex_npc_reg;

  cfe_op_t op;
  assign op = cfe_op_t'(dec_op);

  // ---------------- register port decode ----------------
  wire flags_sel   = (reg_addr == ADDR_W'(`CFE_ADDR_FLAGS));
  wire ctrl_sel    = (reg_addr == ADDR_W'(`CFE_ADDR_CTRL));
  wire bus_flag_wr = reg_wr && flags_sel;
  wire bus_ctrl_wr = reg_wr && ctrl_sel;
  wire [31:0] flags_word = {28'h000_0000, flags_reg};
  wire [31:0] ctrl_word  = {31'h0000_0000, ctrl_strict_reg};
  wire [31:0] rd_mux = flags_sel ? flags_word
                     : ctrl_sel  ? ctrl_word
                     : `CFE_ZERO_WORD;
  // read data stand in the cycle after the strobe only
  assign rdata_next = reg_rd ? rd_mux : `CFE_ZERO_WORD;

  // ---------------- condition gating ----------------
  // outside an if-then block a non-branch is unconditional
  wire outside_it = !dec_is_branch && !dec_in_it;
  wire cond_given = (dec_cond != CFE_COND_EVERY_TIME);
  // strict mode flags a stray condition instead of ignoring it
  wire undef_w = outside_it && cond_given && ctrl_strict_reg;
  wire cfe_cond_t cond_eff = outside_it ? CFE_COND_EVERY_TIME
                                        : cfe_cond_t'(dec_cond);

  cfe_cond_if cif ();
  assign cif.cond  = cond_eff;
  // one-cycle execute, so flags_reg already holds the last update
  assign cif.flags = flags_reg;

  cfe_cond_judge u_judge (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (cif)
  );

  wire pass_w = cif.pass && !undef_w;
  wire live_w = dec_valid && pass_w;

  // ---------------- arithmetic ----------------
  wire [32:0] sum33  = {1'b0, dec_opnd_a} + {1'b0, dec_opnd_b};
  wire [32:0] diff33 = {1'b0, dec_opnd_a} - {1'b0, dec_opnd_b};
  wire is_add   = (op == CFE_OP_ADD);
  wire is_sub   = (op == CFE_OP_SUB) || (op == CFE_OP_CMP);
  wire is_arith = is_add || is_sub;
  wire is_logic = (op == CFE_OP_AND) || (op == CFE_OP_ORR)
               || (op == CFE_OP_EOR) || (op == CFE_OP_MOV);

  wire [31:0] alu_res =
      is_add              ? sum33[31:0]
    : is_sub              ? diff33[31:0]
    : (op == CFE_OP_AND)  ? (dec_opnd_a & dec_opnd_b)
    : (op == CFE_OP_ORR)  ? (dec_opnd_a | dec_opnd_b)
    : (op == CFE_OP_EOR)  ? (dec_opnd_a ^ dec_opnd_b)
    : dec_opnd_b;

  wire a_msb = dec_opnd_a[`CFE_MSB];
  wire b_msb = dec_opnd_b[`CFE_MSB];
  wire r_msb = alu_res[`CFE_MSB];

  wire n_new = r_msb;
  wire z_new = (alu_res == `CFE_ZERO_WORD);
  // carry sources; subtract carry means no borrow
  wire c_new = is_add ? sum33[32]
             : is_sub ? !diff33[32]
             : dec_shc;
  wire c_src = is_arith || (is_logic && dec_shc_vld);
  // signed result beyond the 32-bit range
  wire v_new = is_add ? ((a_msb == b_msb) && (r_msb != a_msb))
                      : ((a_msb != b_msb) && (r_msb != a_msb));

  // compares set flags without the suffix, others need it
  wire set_w = dec_set_flags || (op == CFE_OP_CMP);
  wire [3:0] new_flags = {n_new, z_new, c_new, v_new};
  wire [3:0] can_upd   = {1'b1, 1'b1, c_src, is_arith};
  // a failed condition leaves all flags alone
  wire [3:0] upd_w = dec_upd_mask & can_upd & {4{live_w && set_w}};

  // untouched flags keep their value; hardware beats software
  wire [3:0] base_flags = bus_flag_wr ? reg_wdata[3:0] : flags_reg;
  assign flags_next = (new_flags & upd_w) | (base_flags & ~upd_w);

  // ---------------- pc base ----------------
  wire [31:0] pc_plus4 = dec_pc + `CFE_PC_STEP_WIDE;
  // direct branches take pc plus four as is
  // other labels clear bit one for word alignment
  wire [31:0] label_base = dec_direct_br ? pc_plus4
                                         : (pc_plus4 & `CFE_ALIGN_MASK);
  // width changes only the sequential step
  wire [31:0] next_pc = dec_pc + (dec_wide ? `CFE_PC_STEP_WIDE
                                           : `CFE_PC_STEP_NARROW);

  // ---------------- state ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg       <= `CFE_FLAGS_RST;
      ctrl_strict_reg <= `CFE_CTRL_RST;
      rdata_reg       <= `CFE_ZERO_WORD;
    end else if (clk_en) begin
      flags_reg <= flags_next;
      if (bus_ctrl_wr) begin
        ctrl_strict_reg <= reg_wdata[0];
      end
      rdata_reg <= rdata_next;
    end
  end

  // suppressed instruction raises no write or exception
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ex_valid_reg <= 1'b0;
      ex_exec_reg  <= 1'b0;
      ex_wr_en_reg <= 1'b0;
      ex_exc_reg   <= 1'b0;
      ex_undef_reg <= 1'b0;
    end else if (clk_en) begin
      ex_valid_reg <= dec_valid;
      ex_exec_reg  <= live_w;
      ex_wr_en_reg <= live_w && dec_wr_rd && (op != CFE_OP_CMP);
      ex_exc_reg   <= live_w && dec_exc;
      ex_undef_reg <= dec_valid && undef_w;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ex_result_reg <= `CFE_ZERO_WORD;
      ex_base_reg   <= `CFE_ZERO_WORD;
      ex_target_reg <= `CFE_ZERO_WORD;
      ex_npc_reg    <= `CFE_ZERO_WORD;
    end else if (clk_en && dec_valid) begin
      ex_result_reg <= alu_res;
      ex_base_reg   <= label_base;
      ex_target_reg <= label_base + dec_offset;
      ex_npc_reg    <= next_pc;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign app_status_word = flags_reg;
  assign ex_valid        = ex_valid_reg;
  assign ex_exec         = ex_exec_reg;
  assign ex_result       = ex_result_reg;
  assign ex_wr_en        = ex_wr_en_reg;
  assign ex_exc          = ex_exc_reg;
  assign ex_undef        = ex_undef_reg;
  assign ex_label_base   = ex_base_reg;
  assign ex_target       = ex_target_reg;
  assign ex_next_pc      = ex_npc_reg;

  // ---------------- checks ----------------
  // independent 33-bit signed view for the overflow check
  wire [32:0] s_sum = {a_msb, dec_opnd_a} + {b_msb, dec_opnd_b};
  wire        ovf_chk = s_sum[32] != s_sum[31];
  wire [32:0] s_diff = {a_msb, dec_opnd_a} - {b_msb, dec_opnd_b};
  wire        sub_ovf_chk = s_diff[32] != s_diff[31];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_issue;
    clk_en && dec_valid;
  endsequence
  sequence s_flag_op;
    clk_en && live_w && set_w;
  endsequence

  a_direct_base: assert property (
    s_issue and dec_direct_br |=>
      ex_label_base == $past(dec_pc) + `CFE_PC_STEP_WIDE)
    else $error("direct branch pc base wrong");
  a_label_align: assert property (
    s_issue and !dec_direct_br |=>
      ex_label_base == (($past(dec_pc) + `CFE_PC_STEP_WIDE) & `CFE_ALIGN_MASK))
    else $error("label pc base not word aligned");
  a_keep_carry: assert property (
    clk_en && !upd_w[`CFE_FLAG_C] && !bus_flag_wr |=> $stable(app_status_word[`CFE_FLAG_C]))
    else $error("carry changed without update");
  a_fail_quiet: assert property (
    s_issue and !pass_w |=> !ex_exec && !ex_wr_en && !ex_exc
      && ($stable(app_status_word) || $past(bus_flag_wr)))
    else $error("failed condition had an effect");
  a_neg_flag: assert property (
    s_flag_op and dec_upd_mask[`CFE_FLAG_N] |=> app_status_word[`CFE_FLAG_N] == $past(r_msb))
    else $error("negative flag wrong");
  a_zero_flag: assert property (
    s_flag_op and dec_upd_mask[`CFE_FLAG_Z] |=>
      app_status_word[`CFE_FLAG_Z] == ($past(alu_res) == `CFE_ZERO_WORD))
    else $error("zero flag wrong");
  a_sub_carry: assert property (
    s_flag_op and is_sub and dec_upd_mask[`CFE_FLAG_C] |=>
      app_status_word[`CFE_FLAG_C] == ($past(dec_opnd_a) >= $past(dec_opnd_b)))
    else $error("subtract carry wrong");
  a_add_ovf: assert property (
    s_flag_op and is_add and dec_upd_mask[`CFE_FLAG_V] |=>
      app_status_word[`CFE_FLAG_V] == $past(ovf_chk))
    else $error("add overflow flag wrong");
  a_flags_idle: assert property (
    s_issue and !set_w and !bus_flag_wr |=> $stable(app_status_word))
    else $error("flags changed without set suffix");
  a_it_outside: assert property (
    s_issue and outside_it and !ctrl_strict_reg |=> ex_exec)
    else $error("condition applied outside if-then block");
  a_wide_step: assert property (
    s_issue |=> ex_next_pc == $past(dec_pc) +
      ($past(dec_wide) ? `CFE_PC_STEP_WIDE : `CFE_PC_STEP_NARROW))
    else $error("sequential pc step wrong");
  a_fresh_flags: assert property (
    (s_flag_op and dec_upd_mask[`CFE_FLAG_Z]) ##1 (clk_en && dec_valid) |->
      cif.flags[`CFE_FLAG_Z] == $past(z_new))
    else $error("condition judged on stale flags");
  a_sub_ovf: assert property (
    s_flag_op and is_sub and dec_upd_mask[`CFE_FLAG_V] |=>
      app_status_word[`CFE_FLAG_V] == $past(sub_ovf_chk))
    else $error("subtract overflow flag wrong");
  a_shift_carry: assert property (
    s_flag_op and is_logic and dec_shc_vld and dec_upd_mask[`CFE_FLAG_C] |=>
      app_status_word[`CFE_FLAG_C] == $past(dec_shc))
    else $error("shifter carry not taken");
  a_logic_keep_v: assert property (
    s_flag_op and is_logic and !bus_flag_wr |=> $stable(app_status_word[`CFE_FLAG_V]))
    else $error("logic op changed overflow flag");
endmodule : cfe_flag_unit

// ==== cfe_params.svh ====
// constants for the condition flag evaluator
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH
`define CFE_PC_STEP_WIDE   32'h0000_0004
`define CFE_PC_STEP_NARROW 32'h0000_0002
`define CFE_ALIGN_MASK     32'hFFFF_FFFD
`define CFE_FLAG_N         3
`define CFE_FLAG_Z         2
`define CFE_FLAG_C         1
`define CFE_FLAG_V         0
`define CFE_MSB            31
`define CFE_ADDR_FLAGS     2'h0
`define CFE_ADDR_CTRL      2'h1
`define CFE_FLAGS_RST      4'h0
`define CFE_CTRL_RST       1'h0
`define CFE_ZERO_WORD      32'h0000_0000
`endif

// ==== cfe_pkg.sv ====
// types shared by the condition flag evaluator modules
package cfe_pkg;
  typedef enum logic [3:0] {
    CFE_COND_ZERO_SET       = 4'h0,
    CFE_COND_ZERO_CLEAR     = 4'h1,
    CFE_COND_UNS_HIGHER_SAME = 4'h2,
    CFE_COND_CARRY_CLEAR    = 4'h3,
    CFE_COND_NEGATIVE_SET   = 4'h4,
    CFE_COND_POSITIVE_ZERO  = 4'h5,
    CFE_COND_OVERFLOW_SET   = 4'h6,
    CFE_COND_OVERFLOW_CLEAR = 4'h7,
    CFE_COND_UNS_ABOVE      = 4'h8,
    CFE_COND_UNS_AT_MOST    = 4'h9,
    CFE_COND_SIGNED_AT_LEAST = 4'hA,
    CFE_COND_SIGNED_UNDER   = 4'hB,
    CFE_COND_SIGNED_ABOVE   = 4'hC,
    CFE_COND_SIGNED_AT_MOST = 4'hD,
    CFE_COND_EVERY_TIME     = 4'hE,
    CFE_COND_SPARE          = 4'hF
  } cfe_cond_t;

  typedef enum logic [2:0] {
    CFE_OP_ADD  = 3'h0,
    CFE_OP_SUB  = 3'h1,
    CFE_OP_CMP  = 3'h2,
    CFE_OP_AND  = 3'h3,
    CFE_OP_ORR  = 3'h4,
    CFE_OP_EOR  = 3'h5,
    CFE_OP_MOV  = 3'h6,
    CFE_OP_PASS = 3'h7
  } cfe_op_t;
endpackage : cfe_pkg

// ==== cfe_cond_if.sv ====
// carrier between the flag unit and its condition judge
`timescale 1ns/1ps
interface cfe_cond_if;
  import cfe_pkg::*;
  cfe_cond_t  cond;
  logic [3:0] flags;
  logic       pass;
  modport judge (input cond, input flags, output pass);
  modport user (output cond, output flags, input pass);
endinterface : cfe_cond_if

// ==== cfe_cond_judge.sv ====
// condition code judge against the n z c v flags
`timescale 1ns/1ps
`include "cfe_params.svh"
module cfe_cond_judge
  import cfe_pkg::*;
(
  // assertion clocking only
  input wire logic clk,
  input wire logic rst_n,
  // condition and flags
  cfe_cond_if.judge cif
);
  wire n = cif.flags[`CFE_FLAG_N];
  wire z = cif.flags[`CFE_FLAG_Z];
  wire c = cif.flags[`CFE_FLAG_C];
  wire v = cif.flags[`CFE_FLAG_V];
  wire sgn_eq = (n == v);
  wire [15:0] tests;

  assign tests[CFE_COND_ZERO_SET]       = z;
  assign tests[CFE_COND_ZERO_CLEAR]     = !z;
  assign tests[CFE_COND_NEGATIVE_SET]   = n;
  assign tests[CFE_COND_POSITIVE_ZERO]  = !n;
  assign tests[CFE_COND_OVERFLOW_SET]   = v;
  assign tests[CFE_COND_OVERFLOW_CLEAR] = !v;
  assign tests[CFE_COND_UNS_HIGHER_SAME] = c;
  assign tests[CFE_COND_CARRY_CLEAR]     = !c;
  assign tests[CFE_COND_UNS_ABOVE]       = c && !z;
  assign tests[CFE_COND_UNS_AT_MOST]     = !c || z;
  assign tests[CFE_COND_SIGNED_AT_LEAST] = sgn_eq;
  assign tests[CFE_COND_SIGNED_UNDER]    = !sgn_eq;
  assign tests[CFE_COND_SIGNED_ABOVE]    = !z && sgn_eq;
  assign tests[CFE_COND_SIGNED_AT_MOST]  = z || !sgn_eq;
  // always true; the spare code is treated alike
  assign tests[CFE_COND_EVERY_TIME] = 1'b1;
  assign tests[CFE_COND_SPARE]      = 1'b1;

  assign cif.pass = tests[cif.cond];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_zero_cond: assert property (
    (cif.cond == CFE_COND_ZERO_SET) |-> (cif.pass == cif.flags[`CFE_FLAG_Z]))
    else $error("zero-set condition disagrees with flag");
  a_above_cond: assert property (
    (cif.cond == CFE_COND_UNS_ABOVE) |-> (cif.pass == (c && !z)))
    else $error("unsigned-above condition wrong");
  a_signed_cond: assert property (
    (cif.cond == CFE_COND_SIGNED_AT_MOST) |-> (cif.pass == (z || (n != v))))
    else $error("signed-at-most condition wrong");
  a_every_time: assert property (
    (cif.cond == CFE_COND_EVERY_TIME) |-> cif.pass)
    else $error("always condition did not pass");
endmodule : cfe_cond_judge

// ==== cfe_flag_unit_test.sv ====
// self-checking bench for the condition flag evaluator
`timescale 1ns/1ps
module cfe_flag_unit_test
  import cfe_pkg::*;
;
  typedef struct {
    cfe_op_t     op;
    logic [31:0] a;
    logic [31:0] b;
    logic        shv;
    logic        shc;
    logic        set;
    logic [31:0] res;
    logic [3:0]  fl;
  } cfe_row_t;

  logic        clk, rst_n, clk_en, dec_valid, dec_wide, dec_in_it, dec_is_branch, dec_direct_br;
  logic        dec_set_flags, dec_shc, dec_shc_vld, dec_wr_rd, dec_exc, reg_wr, reg_rd;
  logic        ex_valid, ex_exec, ex_wr_en, ex_exc, ex_undef;
  logic [31:0] dec_pc, dec_offset, dec_opnd_a, dec_opnd_b, reg_wdata, reg_rdata;
  logic [31:0] ex_result, ex_label_base, ex_target, ex_next_pc;
  logic [3:0]  dec_cond, dec_upd_mask, app_status_word;
  logic [2:0]  dec_op;
  logic [1:0]  reg_addr;
  int          n_fail, comparisons, cycles;
  logic        ok;
  // flags are {n,z,c,v}; logic ops leave v alone, which the bench zeroes first
  cfe_row_t    rows [10] = '{
    '{CFE_OP_ADD, 32'hFFFF_FFFF, 32'h0000_0001, 1'h0, 1'h0, 1'h1, 32'h0000_0000, 4'h6},
    '{CFE_OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001, 1'h0, 1'h0, 1'h1, 32'h8000_0000, 4'h9},
    '{CFE_OP_SUB, 32'h0000_0005, 32'h0000_0005, 1'h0, 1'h0, 1'h1, 32'h0000_0000, 4'h6},
    '{CFE_OP_SUB, 32'h0000_0000, 32'h0000_0001, 1'h0, 1'h0, 1'h1, 32'hFFFF_FFFF, 4'h8},
    '{CFE_OP_SUB, 32'h8000_0000, 32'h0000_0001, 1'h0, 1'h0, 1'h1, 32'h7FFF_FFFF, 4'h3},
    '{CFE_OP_CMP, 32'h0000_0001, 32'h0000_0002, 1'h0, 1'h0, 1'h0, 32'h0000_0000, 4'h8},
    '{CFE_OP_AND, 32'h0000_F0F0, 32'h0000_0FF0, 1'h1, 1'h1, 1'h1, 32'h0000_00F0, 4'h2},
    '{CFE_OP_ORR, 32'h8000_0000, 32'h0000_0000, 1'h0, 1'h1, 1'h1, 32'h8000_0000, 4'h8},
    '{CFE_OP_EOR, 32'h0000_0005, 32'h0000_0005, 1'h0, 1'h0, 1'h1, 32'h0000_0000, 4'h4},
    '{CFE_OP_MOV, 32'h0000_0000, 32'h0000_1234, 1'h1, 1'h0, 1'h1, 32'h0000_1234, 4'h0}};

  cfe_flag_unit #(.ADDR_W(2)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .dec_valid(dec_valid), .dec_pc(dec_pc), .dec_wide(dec_wide),
    .dec_cond(dec_cond), .dec_in_it(dec_in_it), .dec_is_branch(dec_is_branch), .dec_direct_br(dec_direct_br),
    .dec_offset(dec_offset), .dec_op(dec_op), .dec_set_flags(dec_set_flags), .dec_upd_mask(dec_upd_mask),
    .dec_opnd_a(dec_opnd_a), .dec_opnd_b(dec_opnd_b), .dec_shc(dec_shc), .dec_shc_vld(dec_shc_vld),
    .dec_wr_rd(dec_wr_rd), .dec_exc(dec_exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ex_valid(ex_valid), .ex_exec(ex_exec), .ex_result(ex_result),
    .ex_wr_en(ex_wr_en), .ex_exc(ex_exc), .ex_undef(ex_undef), .ex_label_base(ex_label_base),
    .ex_target(ex_target), .ex_next_pc(ex_next_pc), .app_status_word(app_status_word));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // a hang is cut off well past the roughly one thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    logic [15:0] t;
    {n, z, cy, v} = f;
    t = {2'h3, z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), ~cy | z, cy & ~z, ~v, v, ~n, n, ~cy, cy, ~z, z};
    return t[c];
  endfunction : cond_ok

  task automatic ins(input cfe_op_t op, input logic [31:0] a, input logic [31:0] b, input logic [3:0] c,
                     input logic it, input logic set, input logic [3:0] mask);
    @(posedge clk);
    dec_valid     <= 1'h1;
    dec_op        <= op;
    dec_opnd_a    <= a;
    dec_opnd_b    <= b;
    dec_cond      <= c;
    dec_in_it     <= it;
    dec_set_flags <= set;
    dec_upd_mask  <= mask;
  endtask : ins

  task automatic idle;
    @(posedge clk);
    dec_valid <= 1'h0;
    #1;
  endtask : idle

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp, "read data");
    @(posedge clk);
    #1 chk(reg_rdata, 32'h0000_0000, "read data after its cycle");
  endtask : rd

  initial begin
    {rst_n, clk_en, dec_valid, dec_wide, dec_in_it, dec_is_branch, dec_direct_br, dec_set_flags} = '0;
    {dec_shc, dec_shc_vld, dec_wr_rd, dec_exc, reg_wr, reg_rd, dec_op, dec_cond, dec_upd_mask} = '0;
    {dec_pc, dec_offset, dec_opnd_a, dec_opnd_b, reg_wdata, reg_addr} = '0;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    clk_en <= 1'h1;
    dec_wr_rd <= 1'h1;
    @(posedge clk);
    #1 chk({ex_valid, ex_exec, ex_wr_en, ex_exc, ex_undef, app_status_word}, 32'h0, "reset outputs");
    rd(2'h0, 32'h0000_0000);
    rd(2'h1, 32'h0000_0000);
    wr(2'h3, 32'hFFFF_FFFF);
    rd(2'h3, 32'h0000_0000);
    wr(2'h0, 32'hFFFF_FFFF);
    rd(2'h0, 32'h0000_000F);
    foreach (rows[i]) begin
      wr(2'h0, 32'h0000_0000);
      dec_shc_vld <= rows[i].shv;
      dec_shc <= rows[i].shc;
      ins(rows[i].op, rows[i].a, rows[i].b, 4'hE, 1'h0, rows[i].set, 4'hF);
      idle();
      chk({ex_wr_en, app_status_word}, {rows[i].op != CFE_OP_CMP, rows[i].fl}, "row flags");
      if (rows[i].op != CFE_OP_CMP) chk(ex_result, rows[i].res, "row result");
    end
    dec_shc_vld <= 1'h0;
    wr(2'h0, 32'h0000_000F);
    ins(CFE_OP_ADD, 32'h1, 32'h1, 4'hE, 1'h0, 1'h1, 4'hC);
    idle();
    chk(app_status_word, 4'h3, "partial update");
    ins(CFE_OP_ADD, 32'h0, 32'h0, 4'hE, 1'h0, 1'h0, 4'hF);
    idle();
    chk({ex_exec, app_status_word}, 5'h13, "no set suffix");
    dec_exc <= 1'h1;
    for (int f = 0; f < 16; f++) begin
      for (int c = 0; c < 15; c++) begin
        wr(2'h0, 32'(f));
        ins(CFE_OP_ADD, 32'h0, 32'h0, 4'(c), 1'h1, 1'h1, 4'hF);
        idle();
        ok = cond_ok(4'(c), 4'(f));
        chk({ex_valid, ex_exec, ex_wr_en, ex_exc, app_status_word}, {1'h1, {3{ok}}, ok ? 4'h4 : 4'(f)}, "cond");
      end
    end
    dec_exc <= 1'h0;
    wr(2'h0, 32'h0000_0000);
    ins(CFE_OP_MOV, 32'h0, 32'h7, 4'h0, 1'h0, 1'h0, 4'h0);
    idle();
    chk({ex_exec, ex_undef}, 2'h2, "stray cond lenient");
    wr(2'h1, 32'h0000_0001);
    rd(2'h1, 32'h0000_0001);
    ins(CFE_OP_MOV, 32'h0, 32'h7, 4'h0, 1'h0, 1'h0, 4'h0);
    idle();
    chk({ex_exec, ex_undef}, 2'h1, "stray cond strict");
    dec_is_branch <= 1'h1;
    ins(CFE_OP_PASS, 32'h0, 32'h7, 4'h0, 1'h0, 1'h0, 4'h0);
    idle();
    chk({ex_exec, ex_undef}, 2'h0, "branch cond fails");
    wr(2'h0, 32'h0000_0004);
    ins(CFE_OP_PASS, 32'h0, 32'h7, 4'h0, 1'h0, 1'h0, 4'h0);
    idle();
    chk({ex_exec, ex_undef}, 2'h2, "branch cond passes");
    dec_is_branch <= 1'h0;
    wr(2'h1, 32'h0000_0000);
    dec_pc <= 32'h0000_1002;
    dec_offset <= 32'h0000_0010;
    dec_direct_br <= 1'h1;
    dec_wide <= 1'h1;
    ins(CFE_OP_MOV, 32'h0, 32'h7, 4'hE, 1'h0, 1'h0, 4'h0);
    idle();
    chk(ex_label_base, 32'h0000_1006, "direct base");
    chk({ex_target, ex_next_pc, ex_result}, {32'h0000_1016, 32'h0000_1006, 32'h7}, "wide path");
    dec_direct_br <= 1'h0;
    dec_wide <= 1'h0;
    ins(CFE_OP_MOV, 32'h0, 32'h7, 4'hE, 1'h0, 1'h0, 4'h0);
    idle();
    chk(ex_label_base, 32'h0000_1004, "aligned base");
    chk({ex_target, ex_next_pc, ex_result}, {32'h0000_1014, 32'h0000_1004, 32'h7}, "narrow path");
    wr(2'h0, 32'h0000_0000);
    ins(CFE_OP_CMP, 32'h1, 32'h1, 4'hE, 1'h0, 1'h0, 4'hF);
    ins(CFE_OP_MOV, 32'h0, 32'h9, 4'h0, 1'h1, 1'h0, 4'h0);
    #1 chk({ex_wr_en, app_status_word}, 5'h06, "compare first");
    idle();
    chk({ex_exec, ex_wr_en, ex_result}, {2'h3, 32'h9}, "forwarded flags");
    clk_en <= 1'h0;
    ins(CFE_OP_ADD, 32'h1, 32'h1, 4'hE, 1'h0, 1'h1, 4'hF);
    idle();
    chk({ex_valid, app_status_word}, 5'h16, "clock enable low");
    clk_en <= 1'h1;
    @(posedge clk);
    rst_n <= 1'h0;
    #1 chk({ex_valid, app_status_word}, 5'h00, "second reset");
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(2'h0, 32'h0000_0000);
    ins(CFE_OP_SUB, 32'h3, 32'h1, 4'hE, 1'h0, 1'h1, 4'hF);
    idle();
    chk({ex_valid, ex_exec, app_status_word}, 6'h32, "run after second reset");
    conclude();
  end
endmodule : cfe_flag_unit_test
